// File: hw/tbc_pkg.sv
// package for the trace breakpoint control and status block
package tbc_pkg;

   // ------------------------------------------------------------
   // register selection (coprocessor register number and select)
   // ------------------------------------------------------------
   localparam logic [4:0] TBC_CTRL_REGNUM = 5'h17;
   localparam logic [2:0] TBC_CTRL_SEL = 3'h4;
   localparam logic [4:0] TBC_STAT_REGNUM = 5'h17;
   localparam logic [2:0] TBC_STAT_SEL = 3'h6;

   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int TBC_NUM_BP = 8;
   localparam int TBC_DATA_SEL_BIT = 31;
   localparam int TBC_DATA_EN_LSB = 16;
   localparam int TBC_INSTR_SEL_BIT = 15;
   localparam int TBC_INSTR_EN_LSB = 0;
   localparam int TBC_PASS_CNT_BIT = 0;
   localparam int TBC_TUPLE_BIT = 1;
   localparam int TBC_DQUAL_BIT = 2;
   localparam int TBC_PRIMED_BIT = 3;
   localparam int TBC_STAT_RSVD_BIT = 31;

   // enables that exist on every variant; the rest need the mmu core
   localparam logic [7:0] TBC_DATA_EN_BASE_MASK = 8'h03;
   localparam logic [7:0] TBC_INSTR_EN_BASE_MASK = 8'h3F;
   localparam logic [7:0] TBC_ALL_MASK = 8'hFF;
   localparam logic [7:0] TBC_EN_RESET = 8'h00;
   localparam logic [3:0] TBC_FLAGS_RESET = 4'h0;
   localparam logic [31:0] TBC_ZERO_WORD = 32'h0000_0000;

   // coprocessor register access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] regnum;
      logic [2:0] sel;
      logic [31:0] wdata;
   } tbc_cop_req_s;

   // complex breakpoint features seen with a debug exception
   typedef struct packed {
      logic primed;
      logic dqual;
      logic tuple;
      logic pass_cnt;
   } tbc_cbp_flags_s;

endpackage

// File: hw/tbc_trig_gate.sv
// gates one group of breakpoint triggers into trace start requests
`timescale 1ns/1ps
`default_nettype none
module tbc_trig_gate (
   // controls
   input wire logic group_sel,
   input wire logic [7:0] enables,
   // triggers in, starts out
   input wire logic [7:0] trig,
   output logic [7:0] start
);
   // ------------------------------------------------------------
   // per breakpoint gating
   // ------------------------------------------------------------
   for (genvar i = 0; i < 8; i++) begin : g_bp
      // group select blocks all, then each enable passes its own
      assign start[i] = group_sel & enables[i] & trig[i];
   end
endmodule
`default_nettype wire

// File: hw/tbc_status_cap.sv
// captures complex breakpoint features on each debug exception
`timescale 1ns/1ps
`default_nettype none
module tbc_status_cap (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // capture
   input wire logic dbg_exc,
   input wire tbc_pkg::tbc_cbp_flags_s flags_in,
   output tbc_pkg::tbc_cbp_flags_s flags_q
);
   import tbc_pkg::*;

   // ------------------------------------------------------------
   // capture register
   // ------------------------------------------------------------
   // (R14) hardware capture only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_q <= TBC_FLAGS_RESET;
      end else if (ce && dbg_exc) begin
         flags_q <= flags_in;
      end
   end
endmodule
`default_nettype wire

// File: hw/tbc_top.sv
// trace breakpoint control and complex breakpoint status registers
//
// Function
// (R1) data bp 0 enable lets its trigger start tracing
// (R2) instruction trigger select passes or blocks all instruction triggers
// (R3) control bits 14 to 8 read zero
// (R4) eight instruction enables gate each instruction trigger
// (R5) instruction enables 7 and 6 only on mmu variants
// (R6) status register exists only with complex breakpoints
// (R7) status bit 31 reads one, bits 30 to 4 zero
// (R8) status bit 3 shows primed complex breakpoint on last exception
// (R9) status bit 2 shows data qualified breakpoint on last exception
// (R10) status bit 1 shows tuple breakpoint on last exception
// (R11) status bit 0 shows pass counter breakpoint on last exception
// (R12) data trigger select passes or blocks all data triggers
// (R13) data enables 1 to 7 at bits 17 to 23; 2 to 7 mmu only
// (R14) status flags captured by hardware, software writes ignored
`timescale 1ns/1ps
`default_nettype none
module tbc_top #(
   parameter bit HAS_MMU = 1'b1,
   parameter bit HAS_COMPLEX_BP = 1'b1
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // coprocessor register moves
   input wire tbc_pkg::tbc_cop_req_s cop_req,
   output logic [31:0] cop_rdata,
   // breakpoint units
   input wire logic [7:0] data_bp_trig,
   input wire logic [7:0] instr_bp_trig,
   input wire logic dbg_exc,
   input wire tbc_pkg::tbc_cbp_flags_s cbp_flags,
   // trace control
   output logic [7:0] data_trace_start,
   output logic [7:0] instr_trace_start,
   output logic trace_start
);
   import tbc_pkg::*;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   function automatic logic hit(input tbc_cop_req_s r, input logic [4:0] n,
                                input logic [2:0] s);
      hit = (r.regnum == n) && (r.sel == s);
   endfunction

   logic ctrl_hit;
   logic stat_hit;
   logic [7:0] data_mask;
   logic [7:0] instr_mask;

   assign ctrl_hit = hit(cop_req, TBC_CTRL_REGNUM, TBC_CTRL_SEL);
   // (R6) status present only with complex breakpoints
   assign stat_hit = HAS_COMPLEX_BP && hit(cop_req, TBC_STAT_REGNUM, TBC_STAT_SEL);
   // (R5) upper instruction enables mmu only
   assign instr_mask = HAS_MMU ? TBC_ALL_MASK : TBC_INSTR_EN_BASE_MASK;
   // (R13) data enables 2 to 7 mmu only
   assign data_mask = HAS_MMU ? TBC_ALL_MASK : TBC_DATA_EN_BASE_MASK;

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   logic data_bp_trigger_select_q;
   logic instr_bp_trigger_select_q;
   logic [7:0] data_bp_trace_start_q;
   logic [7:0] instr_bp_trace_start_q;

   // (R12) data trigger select storage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_bp_trigger_select_q <= 1'b0;
         instr_bp_trigger_select_q <= 1'b0;
      end else if (ce && cop_req.wr && ctrl_hit) begin
         data_bp_trigger_select_q <= cop_req.wdata[TBC_DATA_SEL_BIT];
         // (R2) instruction select storage
         instr_bp_trigger_select_q <= cop_req.wdata[TBC_INSTR_SEL_BIT];
      end
   end

   // unimplemented enable bits stay zero, so they read back zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_bp_trace_start_q <= TBC_EN_RESET;
         instr_bp_trace_start_q <= TBC_EN_RESET;
      end else if (ce && cop_req.wr && ctrl_hit) begin
         // (R13) data enables at 23:16
         data_bp_trace_start_q <= cop_req.wdata[TBC_DATA_EN_LSB +: 8] & data_mask;
         // (R4) instruction enables at 7:0
         instr_bp_trace_start_q <= cop_req.wdata[TBC_INSTR_EN_LSB +: 8] & instr_mask;
      end
   end

   // ------------------------------------------------------------
   // trigger gating
   // ------------------------------------------------------------
   logic [7:0] data_start;
   logic [7:0] instr_start;

   // (R1) data bp 0 gated by bit 16 enable
   tbc_trig_gate u_data_gate (
      .group_sel(data_bp_trigger_select_q),
      .enables(data_bp_trace_start_q),
      .trig(data_bp_trig),
      .start(data_start)
   );

   // (R4) instruction triggers gated per enable
   tbc_trig_gate u_instr_gate (
      .group_sel(instr_bp_trigger_select_q),
      .enables(instr_bp_trace_start_q),
      .trig(instr_bp_trig),
      .start(instr_start)
   );

   // registered so trace control sees a clean level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_trace_start <= TBC_EN_RESET;
         instr_trace_start <= TBC_EN_RESET;
         trace_start <= 1'b0;
      end else if (ce) begin
         data_trace_start <= data_start;
         instr_trace_start <= instr_start;
         trace_start <= |{data_start, instr_start};
      end
   end

   // ------------------------------------------------------------
   // complex breakpoint status
   // ------------------------------------------------------------
   tbc_cbp_flags_s flags_q;

   // (R14) flags follow debug exceptions only
   tbc_status_cap u_stat (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .dbg_exc(dbg_exc),
      .flags_in(cbp_flags),
      .flags_q(flags_q)
   );

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;

   // (R3) bits 30:24 and 14:8 left zero
   always_comb begin
      ctrl_word = TBC_ZERO_WORD;
      ctrl_word[TBC_DATA_SEL_BIT] = data_bp_trigger_select_q;
      ctrl_word[TBC_DATA_EN_LSB +: 8] = data_bp_trace_start_q;
      ctrl_word[TBC_INSTR_SEL_BIT] = instr_bp_trigger_select_q;
      ctrl_word[TBC_INSTR_EN_LSB +: 8] = instr_bp_trace_start_q;
   end

   // (R7) reserved top bit one, rest zero
   always_comb begin
      stat_word = TBC_ZERO_WORD;
      stat_word[TBC_STAT_RSVD_BIT] = 1'b1;
      // (R8) primed flag
      stat_word[TBC_PRIMED_BIT] = flags_q.primed;
      // (R9) data qualified flag
      stat_word[TBC_DQUAL_BIT] = flags_q.dqual;
      // (R10) tuple flag
      stat_word[TBC_TUPLE_BIT] = flags_q.tuple;
      // (R11) pass counter flag
      stat_word[TBC_PASS_CNT_BIT] = flags_q.pass_cnt;
   end

   // read data held in a flop; unmapped selects return zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cop_rdata <= TBC_ZERO_WORD;
      end else if (ce && cop_req.rd) begin
         if (ctrl_hit) begin
            cop_rdata <= ctrl_word;
         end else if (stat_hit) begin
            cop_rdata <= stat_word;
         end else begin
            cop_rdata <= TBC_ZERO_WORD;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/tbc_bp_model.sv
// breakpoint unit model driving triggers and exception flags
`timescale 1ns/1ps
`default_nettype none
module tbc_bp_model import tbc_pkg::*; (
   // requests from the bench
   input wire logic clk,
   input wire logic [7:0] d_req,
   input wire logic [7:0] i_req,
   input wire logic exc_req,
   input wire tbc_pkg::tbc_cbp_flags_s f_req,
   // to the block
   output logic [7:0] data_bp_trig,
   output logic [7:0] instr_bp_trig,
   output logic dbg_exc,
   output tbc_pkg::tbc_cbp_flags_s cbp_flags
);
   initial begin
      data_bp_trig = 8'h00;
      instr_bp_trig = 8'h00;
      dbg_exc = 1'b0;
      cbp_flags = '0;
   end
   // flags mean nothing without the pulse, so show their inverse then
   always @(negedge clk) begin
      data_bp_trig <= d_req;
      instr_bp_trig <= i_req;
      dbg_exc <= exc_req;
      cbp_flags <= exc_req ? f_req : ~f_req;
   end
endmodule
`default_nettype wire

// File: tb/tbc_top_chk.sv
// port checker for the trace breakpoint block
`timescale 1ns/1ps
`default_nettype none
module tbc_top_chk import tbc_pkg::*; #(
   parameter bit HAS_MMU = 1'b1,
   parameter bit HAS_COMPLEX_BP = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // register moves
   input wire tbc_pkg::tbc_cop_req_s cop_req,
   input wire logic [31:0] cop_rdata,
   // breakpoint side
   input wire logic [7:0] data_bp_trig,
   input wire logic [7:0] instr_bp_trig,
   input wire logic dbg_exc,
   input wire tbc_pkg::tbc_cbp_flags_s cbp_flags,
   input wire logic [7:0] data_trace_start,
   input wire logic [7:0] instr_trace_start,
   input wire logic trace_start
);
   localparam logic [31:0] CMASK = {8'h80, HAS_MMU ? 8'hFF : 8'h03, 8'h80, HAS_MMU ? 8'hFF : 8'h3F};
   logic [31:0] ctl_q;
   logic [3:0] flg_q;
   logic is_ctl;
   logic is_st;
   logic [7:0] exp_d;
   logic [7:0] exp_i;
   logic [31:0] st_w;
   // shadow of what software and the exception should have left
   assign is_ctl = cop_req.regnum == TBC_CTRL_REGNUM && cop_req.sel == TBC_CTRL_SEL;
   assign is_st = cop_req.regnum == TBC_STAT_REGNUM && cop_req.sel == TBC_STAT_SEL;
   assign exp_d = ctl_q[31] ? data_bp_trig & ctl_q[23:16] : 8'h00;
   assign exp_i = ctl_q[15] ? instr_bp_trig & ctl_q[7:0] : 8'h00;
   assign st_w = HAS_COMPLEX_BP ? {8'h80, 20'h00000, flg_q} : 32'h00000000;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ctl_q <= '0;
      else if (ce && cop_req.wr && is_ctl) ctl_q <= cop_req.wdata & CMASK;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) flg_q <= '0;
      else if (ce && dbg_exc) flg_q <= cbp_flags;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_TS_OR: assert property (trace_start == (|{data_trace_start, instr_trace_start}))
      else $error("trace start is not the or of starts");
   AST_DATA_GATE: assert property (ce |=> data_trace_start == $past(exp_d))
      else $error("data start gating wrong");
   AST_INSTR_GATE: assert property (ce |=> instr_trace_start == $past(exp_i))
      else $error("instr start gating wrong");
   AST_RD_CTRL: assert property (ce && cop_req.rd && is_ctl |=> cop_rdata == $past(ctl_q))
      else $error("control read wrong");
   AST_RD_STAT: assert property (ce && cop_req.rd && is_st |=> cop_rdata == $past(st_w))
      else $error("status read wrong");
   AST_UNMAP: assert property (ce && cop_req.rd && !is_ctl && !is_st |=> cop_rdata == '0)
      else $error("unmapped read not zero");
   AST_RD_HOLD: assert property (!(ce && cop_req.rd) |=> $stable(cop_rdata))
      else $error("read data moved");
   AST_FREEZE: assert property (!ce |=> $stable(data_trace_start) && $stable(instr_trace_start))
      else $error("starts moved while frozen");
endmodule
bind tbc_top tbc_top_chk #(.HAS_MMU(HAS_MMU), .HAS_COMPLEX_BP(HAS_COMPLEX_BP)) i_chk (
   .clk(clk), .rstn(rstn), .ce(ce), .cop_req(cop_req), .cop_rdata(cop_rdata),
   .data_bp_trig(data_bp_trig), .instr_bp_trig(instr_bp_trig), .dbg_exc(dbg_exc),
   .cbp_flags(cbp_flags), .data_trace_start(data_trace_start),
   .instr_trace_start(instr_trace_start), .trace_start(trace_start));
`default_nettype wire

// File: tb/tbc_top_tb_top.sv
// self-checking bench for the trace breakpoint block
`timescale 1ns/1ps
`default_nettype none
module tbc_top_tb_top;
   import tbc_pkg::*;
   logic clk, rstn, ce, exc, exc_r, ts;
   tbc_cop_req_s req;
   logic [31:0] rdata, rdata_b;
   logic [7:0] dtrig, itrig, dts, its, dreq, ireq;
   tbc_cbp_flags_s fl, freq, fv;
   int n_errors, checks, cyc;
   tbc_top i_dut (.clk(clk), .rstn(rstn), .ce(ce), .cop_req(req), .cop_rdata(rdata),
      .data_bp_trig(dtrig), .instr_bp_trig(itrig), .dbg_exc(exc), .cbp_flags(fl),
      .data_trace_start(dts), .instr_trace_start(its), .trace_start(ts));
   // reduced variant: no mmu, no complex breakpoints
   tbc_top #(.HAS_MMU(1'b0), .HAS_COMPLEX_BP(1'b0)) i_dut_b (.clk(clk), .rstn(rstn), .ce(ce),
      .cop_req(req), .cop_rdata(rdata_b), .data_bp_trig(dtrig), .instr_bp_trig(itrig),
      .dbg_exc(exc), .cbp_flags(fl), .data_trace_start(), .instr_trace_start(),
      .trace_start());
   tbc_bp_model i_bp (.clk(clk), .d_req(dreq), .i_req(ireq), .exc_req(exc_r), .f_req(freq),
      .data_bp_trig(dtrig), .instr_bp_trig(itrig), .dbg_exc(exc), .cbp_flags(fl));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [2:0] sel, input logic [31:0] d);
      @(negedge clk);
      req <= '{rd: 1'b0, wr: 1'b1, regnum: TBC_CTRL_REGNUM, sel: sel, wdata: d};
      @(negedge clk);
      req.wr <= 1'b0;
   endtask
   // read both variants; data is registered one edge after the request
   task automatic rd(input logic [2:0] sel, input logic [31:0] e, input logic [31:0] eb);
      @(negedge clk);
      req <= '{rd: 1'b1, wr: 1'b0, regnum: TBC_CTRL_REGNUM, sel: sel, wdata: 32'h00000000};
      @(negedge clk);
      req.rd <= 1'b0;
      chk("rdata", rdata, e);
      chk("rdata_b", rdata_b, eb);
   endtask
   // model drives on the next falling edge, block samples on the rising one
   task automatic trg(input logic [7:0] d, input logic [7:0] i, input logic [7:0] ed,
                      input logic [7:0] ei);
      @(posedge clk);
      dreq = d;
      ireq = i;
      repeat (2) @(negedge clk);
      chk("data starts", 32'(dts), 32'(ed));
      chk("instr starts", 32'(its), 32'(ei));
      chk("trace start", 32'(ts), 32'(|{ed, ei}));
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         give_verdict;
      end
   end
   initial begin
      {rstn, exc_r, dreq, ireq, freq, fv, req} = '0;
      ce = 1'b1;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      rd(TBC_CTRL_SEL, 32'h00000000, 32'h00000000);
      rd(TBC_STAT_SEL, 32'h80000000, 32'h00000000);
      wr(TBC_CTRL_SEL, 32'hFFFFFFFF);
      rd(TBC_CTRL_SEL, 32'h80FF80FF, 32'h8003803F);
      wr(TBC_STAT_SEL, 32'hFFFFFFFF);
      rd(TBC_STAT_SEL, 32'h80000000, 32'h00000000);
      rd(3'h0, 32'h00000000, 32'h00000000);
      $display("register test done");
      for (int k = 0; k < 8; k++) begin
         wr(TBC_CTRL_SEL, 32'h80008000 | (32'h1 << (16 + k)) | (32'h1 << k));
         trg(8'hFF, 8'hFF, 8'h01 << k, 8'h01 << k);
      end
      wr(TBC_CTRL_SEL, 32'h00FF00FF);
      trg(8'hFF, 8'hFF, 8'h00, 8'h00);
      wr(TBC_CTRL_SEL, 32'h80FF00FF);
      trg(8'hA5, 8'hFF, 8'hA5, 8'h00);
      wr(TBC_CTRL_SEL, 32'h00FF80FF);
      trg(8'hFF, 8'h5A, 8'h00, 8'h5A);
      @(negedge clk);
      ce = 1'b0;
      trg(8'h00, 8'hFF, 8'h00, 8'h5A);
      ce = 1'b1;
      $display("trigger test done");
      for (int k = 0; k < 5; k++) begin
         fv = (k < 4) ? 4'h1 << k : 4'hA;
         @(posedge clk);
         freq = fv;
         exc_r = 1'b1;
         @(posedge clk);
         exc_r = 1'b0;
         rd(TBC_STAT_SEL, {8'h80, 20'h00000, fv}, 32'h00000000);
      end
      $display("status test done");
      give_verdict;
   end
endmodule
`default_nettype wire
